/* rtl/fsq_params.svh */
// Named constants for the serial flash command sequencer
`ifndef FSQ_PARAMS_SVH
`define FSQ_PARAMS_SVH

// Opcode table shared with the host (values are this block's own)
`define FSQ_OPC_READ 8'h03
`define FSQ_OPC_WRITE 8'h02
`define FSQ_OPC_ERASE 8'h20

// Frame header: opcode byte then 16-bit address, MSB first
`define FSQ_HEAD_W 24
`define FSQ_HEAD_LAST 5'h17
`define FSQ_OPC_FIELD 23:16
`define FSQ_WIDX_FIELD 12:1
`define FSQ_BLKW_FIELD 11:7

// Array shape: 4096 words of 16 bits, 32 blocks of 128 words
`define FSQ_WORD_W 16
`define FSQ_WIDX_W 12
`define FSQ_WORDS 4096
`define FSQ_BLK_W 5
`define FSQ_EOFS_W 7
`define FSQ_EOFS_LAST 7'h7F
`define FSQ_WIDX_FIRST 12'h000
`define FSQ_WIDX_LAST 12'hFFF
`define FSQ_ERASED 16'hFFFF

// Bit counters inside a data word
`define FSQ_BIT_W 4
`define FSQ_BIT_FIRST 4'h0
`define FSQ_BIT_LAST 4'hF

// Read prefetch buffer and pin idle levels (sck, ce_n, din)
`define FSQ_FIFO_DEPTH 8
`define FSQ_PINS_IDLE 3'h2

`endif

/* rtl/fsq_pkg.sv */
// Types shared by the serial flash command sequencer
package fsq_pkg;

	// Synchronised serial pin sample
	typedef struct packed {
		logic sck;
		logic ce_n;
		logic din;
	} fsq_pins_t;

	// Progress of one chip-enable frame
	typedef enum logic [2:0] {
		FR_IDLE,
		FR_HEAD,
		FR_READ,
		FR_WRITE,
		FR_ERASE,
		FR_SKIP
	} fsq_frame_t;

	// Background array engine
	typedef enum logic {
		ENG_IDLE,
		ENG_ERASE
	} fsq_eng_t;

endpackage

/* rtl/fsq_top.sv */
// Serial flash command sequencer: prefetch FIFO and sequencer top
`timescale 1ns/100ps
// Notes on behaviour
// - Only read, write, erase commands accepted
// - Read streams incrementing words until release
// - Read start given by 13-bit address
// - Read counter wraps from last to first
// - One 16-bit word programmed per write
// - Program last whole word, drop partial
// - Write completion sets done, raises interrupt
// - Erase clears 128-word block of 32
// - Erase hits block holding given address
// - Erase completion sets done, raises interrupt
// - Erased locations read back all ones
`include "fsq_params.svh"

// ****************************************
// Prefetch FIFO
// ****************************************
module fsq_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and control
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_q, rp_q;
	logic push, pop;

	// Extra pointer bit tells full from empty
	assign in_ready = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
	assign out_valid = wp_q != rp_q;
	assign out_data = mem[rp_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointers
	always_ff @(posedge clock) begin
		if (!rst_n || (clk_en && flush)) begin
			wp_q <= '0;
			rp_q <= '0;
		end else if (clk_en) begin
			if (push)
				wp_q <= wp_q + 1'h1;
			if (pop)
				rp_q <= rp_q + 1'h1;
		end
	end

	// Storage
	always_ff @(posedge clock) begin
		if (clk_en && push)
			mem[wp_q[AW-1:0]] <= in_data;
	end
endmodule

// ****************************************
// Sequencer top
// ****************************************
module fsq_top
	import fsq_pkg::*;
(
	// Clock, reset, freeze
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Serial pins
	input wire logic spi_sck,
	input wire logic spi_ce_n,
	input wire logic spi_din,
	output logic spi_dout,
	// Side controls
	input wire logic regulator_en,
	input wire logic int_enable,
	input wire logic done_clear,
	// Status
	output logic mem_done,
	output logic mem_busy,
	output logic int_n
);
	// Factory state is all blank; reset leaves the array alone
	logic [`FSQ_WORD_W-1:0] mem [`FSQ_WORDS] = '{default: `FSQ_ERASED};
	fsq_pins_t s1_q, s2_q, s3_q;
	fsq_frame_t frame_q, frame_dec;
	fsq_eng_t eng_q;
	logic rise, fall, ce_start, ce_end, head_done;
	logic [`FSQ_HEAD_W-1:0] head_q, head_d;
	logic [4:0] hcnt_q;
	logic [`FSQ_WIDX_W-1:0] cmd_addr_q, rd_addr_q;
	logic [`FSQ_WORD_W-1:0] wsh_q, last_q, osh_q;
	logic [`FSQ_BIT_W-1:0] wcnt_q, ocnt_q;
	logic have_q, rd_on_q, dout_q, done_q, busy_q, int_n_q;
	logic [`FSQ_BLK_W-1:0] eblk_q;
	logic [`FSQ_EOFS_W-1:0] ecnt_q;
	logic [`FSQ_WIDX_W-1:0] eidx;
	logic prog_go, erase_go, erase_end, done_set, pop;
	logic push_ready, fifo_valid;
	logic [`FSQ_WORD_W-1:0] fifo_word;

	// Pins pass two flops; a third holds the previous sample
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s1_q <= `FSQ_PINS_IDLE;
			s2_q <= `FSQ_PINS_IDLE;
			s3_q <= `FSQ_PINS_IDLE;
		end else if (clk_en) begin
			s1_q <= {spi_sck, spi_ce_n, spi_din};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Sck edge events, seen only while selected, and chip-enable frame events
	assign ce_start = !s2_q.ce_n && s3_q.ce_n;
	assign ce_end = s2_q.ce_n && !s3_q.ce_n;
	assign rise = !s2_q.ce_n && s2_q.sck && !s3_q.sck;
	assign fall = !s2_q.ce_n && !s2_q.sck && s3_q.sck;
	assign head_d = {head_q[`FSQ_HEAD_W-2:0], s2_q.din};
	assign head_done = rise && frame_q == FR_HEAD && hcnt_q == `FSQ_HEAD_LAST;

	// Opcode decode; anything unknown is shifted through and ignored
	always_comb begin
		frame_dec = FR_SKIP;
		if (regulator_en) begin
			case (head_d[`FSQ_OPC_FIELD])
				`FSQ_OPC_READ: frame_dec = FR_READ;
				`FSQ_OPC_WRITE: frame_dec = FR_WRITE;
				`FSQ_OPC_ERASE: frame_dec = FR_ERASE;
				default: frame_dec = FR_SKIP;
			endcase
		end
	end

	// Frame state follows chip enable
	always_ff @(posedge clock) begin
		if (!rst_n)
			frame_q <= FR_IDLE;
		else if (clk_en) begin
			if (ce_start)
				frame_q <= FR_HEAD;
			else if (s2_q.ce_n)
				frame_q <= FR_IDLE;
			else if (head_done)
				frame_q <= frame_dec;
		end
	end

	// Header shift: opcode then address word
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			head_q <= '0;
			hcnt_q <= '0;
			cmd_addr_q <= `FSQ_WIDX_FIRST;
		end else if (clk_en) begin
			if (ce_start)
				hcnt_q <= '0;
			else if (rise && frame_q == FR_HEAD) begin
				head_q <= head_d;
				hcnt_q <= hcnt_q + 1'h1;
			end
			if (head_done)
				cmd_addr_q <= head_d[`FSQ_WIDX_FIELD];
		end
	end

	// Write data: keep only the last whole word, no queue
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wsh_q <= '0;
			wcnt_q <= `FSQ_BIT_FIRST;
			last_q <= `FSQ_ERASED;
			have_q <= 1'h0;
		end else if (clk_en) begin
			if (ce_start) begin
				wcnt_q <= `FSQ_BIT_FIRST;
				have_q <= 1'h0;
			end else if (rise && frame_q == FR_WRITE) begin
				wsh_q <= {wsh_q[`FSQ_WORD_W-2:0], s2_q.din};
				wcnt_q <= wcnt_q + 1'h1;
				if (wcnt_q == `FSQ_BIT_LAST) begin
					last_q <= {wsh_q[`FSQ_WORD_W-2:0], s2_q.din};
					have_q <= 1'h1;
				end
			end
		end
	end

	// Read address counter feeds the prefetch FIFO
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_on_q <= 1'h0;
			rd_addr_q <= `FSQ_WIDX_FIRST;
		end else if (clk_en) begin
			if (ce_start || ce_end)
				rd_on_q <= 1'h0;
			else if (head_done && frame_dec == FR_READ) begin
				rd_on_q <= 1'h1;
				rd_addr_q <= head_d[`FSQ_WIDX_FIELD];
			end else if (rd_on_q && push_ready) begin
				if (rd_addr_q == `FSQ_WIDX_LAST)
					rd_addr_q <= `FSQ_WIDX_FIRST;
				else
					rd_addr_q <= rd_addr_q + 1'h1;
			end
		end
	end

	// Stalls the counter when full; flushed at each frame edge
	fsq_fifo #(
		.WIDTH(`FSQ_WORD_W),
		.DEPTH(`FSQ_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.flush(ce_start || ce_end),
		.in_valid(rd_on_q),
		.in_ready(push_ready),
		.in_data(mem[rd_addr_q]),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_word)
	);

	// Output shifter changes on falling sck, MSB first
	assign pop = fall && frame_q == FR_READ && ocnt_q == `FSQ_BIT_FIRST;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dout_q <= 1'h0;
			osh_q <= '0;
			ocnt_q <= `FSQ_BIT_FIRST;
		end else if (clk_en) begin
			if (frame_q != FR_READ) begin
				dout_q <= 1'h0;
				ocnt_q <= `FSQ_BIT_FIRST;
			end else if (fall) begin
				ocnt_q <= ocnt_q + 1'h1;
				if (pop) begin
					dout_q <= fifo_word[`FSQ_WORD_W-1];
					osh_q <= {fifo_word[`FSQ_WORD_W-2:0], 1'h0};
				end else begin
					dout_q <= osh_q[`FSQ_WORD_W-1];
					osh_q <= {osh_q[`FSQ_WORD_W-2:0], 1'h0};
				end
			end
		end
	end

	// Commands act at release; a busy engine drops the new one
	assign prog_go = ce_end && frame_q == FR_WRITE && have_q && !busy_q;
	assign erase_go = ce_end && frame_q == FR_ERASE && !busy_q;
	assign erase_end = eng_q == ENG_ERASE && ecnt_q == `FSQ_EOFS_LAST;
	assign eidx = {eblk_q, ecnt_q};

	// Erase engine sweeps one word per cycle through the block
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			eng_q <= ENG_IDLE;
			busy_q <= 1'h0;
			ecnt_q <= '0;
			eblk_q <= '0;
		end else if (clk_en) begin
			if (erase_go) begin
				eng_q <= ENG_ERASE;
				busy_q <= 1'h1;
				ecnt_q <= '0;
				eblk_q <= cmd_addr_q[`FSQ_BLKW_FIELD];
			end else if (eng_q == ENG_ERASE) begin
				ecnt_q <= ecnt_q + 1'h1;
				if (erase_end) begin
					eng_q <= ENG_IDLE;
					busy_q <= 1'h0;
				end
			end
		end
	end

	// Array writes; program overwrites, so no erase is needed first
	always_ff @(posedge clock) begin
		if (clk_en) begin
			if (prog_go)
				mem[cmd_addr_q] <= last_q;
			else if (eng_q == ENG_ERASE)
				mem[eidx] <= `FSQ_ERASED;
		end
	end

	// Done flag: a set in the clearing cycle wins
	assign done_set = prog_go || erase_end;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			done_q <= 1'h0;
			int_n_q <= 1'h1;
		end else if (clk_en) begin
			if (done_set)
				done_q <= 1'h1;
			else if (done_clear)
				done_q <= 1'h0;
			int_n_q <= !(done_q && int_enable);
		end
	end

	assign spi_dout = dout_q;
	assign mem_done = done_q;
	assign mem_busy = busy_q;
	assign int_n = int_n_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n || !clk_en);

	sequence s_erase_start;
		erase_go ##1 busy_q [*8];
	endsequence

	a_erase_done: assert property (s_erase_start |-> ##121 done_q)
		else $error("erase did not finish in 128 words");
	a_erase_busy: assert property (erase_go |=> busy_q [*8])
		else $error("erase engine idle too soon");
	a_erase_ones: assert property (eng_q == ENG_ERASE |=>
		mem[$past(eidx)] == `FSQ_ERASED)
		else $error("erased word not all ones");
	a_prog_word: assert property (prog_go |=>
		mem[$past(cmd_addr_q)] == $past(last_q) && done_q)
		else $error("program word or done wrong");
	a_read_wrap: assert property (rd_on_q && push_ready &&
		rd_addr_q == `FSQ_WIDX_LAST && !ce_end && !ce_start |=>
		rd_addr_q == `FSQ_WIDX_FIRST)
		else $error("read counter did not wrap");
	a_read_stop: assert property (ce_end |=> !rd_on_q ##1 !fifo_valid)
		else $error("read stream ran past release");
	a_int_pin: assert property (done_q && int_enable |=> !int_n)
		else $error("interrupt pin not asserted");
	a_set_wins: assert property (done_set && done_clear |=> done_q)
		else $error("done clear beat a completion");
	a_only_three: assert property (head_done &&
		head_d[`FSQ_OPC_FIELD] != `FSQ_OPC_READ &&
		head_d[`FSQ_OPC_FIELD] != `FSQ_OPC_WRITE &&
		head_d[`FSQ_OPC_FIELD] != `FSQ_OPC_ERASE && !s2_q.ce_n
		|=> frame_q == FR_SKIP)
		else $error("unknown opcode accepted");
	a_dout_msb: assert property (pop |=>
		spi_dout == $past(fifo_word[`FSQ_WORD_W-1]))
		else $error("word not sent MSB first");
endmodule

/* bench/fsq_host.sv */
// Host model that drives the serial frame pins of the sequencer
`timescale 1ns/100ps
module fsq_host (
	// Serial pins towards the sequencer
	output logic spi_sck,
	output logic spi_ce_n,
	output logic spi_din,
	input wire logic spi_dout
);
	// ****************************************
	// Idle pins and frame tasks
	// ****************************************

	// Clock parked low and chip enable released outside frames
	initial begin
		spi_sck = 1'b0;
		spi_ce_n = 1'b1;
		spi_din = 1'b0;
	end

	// Mode 0: data set while sck is low, sampled on the rise
	task automatic xfer(input logic [63:0] v, input int n,
		inout logic [63:0] r);
		for (int i = n - 1; i >= 0; i--) begin
			spi_din = v[i];
			#24 spi_sck = 1'b1;
			r = {r[62:0], spi_dout};
			#24 spi_sck = 1'b0;
		end
	endtask

	// Opcode, even address, data; din flips so stale bits never look valid
	task automatic frame(input logic [7:0] op, input logic [15:0] a,
		input logic [63:0] d, input int n, output logic [63:0] r);
		r = 64'h0;
		spi_ce_n = 1'b0;
		#13.3 xfer({40'h0, op, a & 16'hFFFE}, 24, r);
		xfer(d, n, r);
		spi_din = ~spi_din;
		#24 spi_ce_n = 1'b1;
		#60 spi_din = ~spi_din;
	endtask
endmodule

/* bench/fsq_tb_top.sv */
// Self-checking bench for the serial flash command sequencer
`timescale 1ns/100ps
`include "fsq_params.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	err_total++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module fsq_tb_top;
	logic clock, rst_n, clk_en, regulator_en, int_enable, done_clear;
	logic spi_sck, spi_ce_n, spi_din, spi_dout, mem_done, mem_busy, int_n;
	logic [63:0] rd;
	int err_total = 0;
	int check_count = 0;

	// ****************************************
	// Clock and instances
	// ****************************************

	// 250 MHz system clock
	always #2 clock = ~clock;

	fsq_top uut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.spi_sck(spi_sck), .spi_ce_n(spi_ce_n), .spi_din(spi_din),
		.spi_dout(spi_dout), .regulator_en(regulator_en),
		.int_enable(int_enable), .done_clear(done_clear),
		.mem_done(mem_done), .mem_busy(mem_busy), .int_n(int_n));
	fsq_host host (.spi_sck(spi_sck), .spi_ce_n(spi_ce_n),
		.spi_din(spi_din), .spi_dout(spi_dout));

	// ****************************************
	// Shared tasks
	// ****************************************

	// Side inputs change 1 ns after the edge, never on it
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Pulse the clear of the sticky done flag
	task automatic clr_done();
		done_clear = 1'b1;
		tick(1);
		done_clear = 1'b0;
		tick(1);
	endtask

	// One host frame, then realign to the system clock
	task automatic run(input logic [7:0] op, input logic [15:0] a,
		input logic [63:0] d, input int n);
		host.frame(op, a, d, n, rd);
		tick(1);
	endtask

	// Bounded wait: an erase needs 129 cycles, so 300 is ample
	task automatic wait_done(input logic e);
		int k;
		k = 0;
		while (mem_done !== 1'b1 && k < 300) begin
			tick(1);
			k++;
		end
		`CHK("mem_done", e, mem_done)
	endtask

	// ****************************************
	// Scenarios
	// ****************************************

	// Blank array reads all ones at the top word and after the wrap
	task automatic t_blank();
		run(`FSQ_OPC_READ, 16'h1FFE, 64'h0, 32);
		`CHK("blank", 32'hFFFFFFFF, rd[31:0])
	endtask

	// Erase through an address deep inside block 31
	task automatic t_erase();
		run(`FSQ_OPC_ERASE, 16'h1F42, 64'h0, 0);
		`CHK("mem_busy", 1'b1, mem_busy)
		`CHK("mem_done", 1'b0, mem_done)
		// Freeze longer than a whole erase: the engine must not move
		clk_en = 1'b0;
		tick(200);
		`CHK("frozen busy", 1'b1, mem_busy)
		`CHK("frozen done", 1'b0, mem_done)
		clk_en = 1'b1;
		wait_done(1'b1);
		tick(2);
		`CHK("int_n", 1'b0, int_n)
		clr_done();
		tick(1);
		`CHK("int_n", 1'b1, int_n)
	endtask

	// Long write keeps its last whole word; read streams across the wrap
	task automatic t_write();
		run(`FSQ_OPC_WRITE, 16'h1FFE, {11'h0, 48'hA5A55A5A1357, 5'h1F}, 53);
		wait_done(1'b1);
		`CHK("int_n", 1'b0, int_n)
		clr_done();
		int_enable = 1'b0;
		run(`FSQ_OPC_WRITE, 16'h0000, 64'h2468, 16);
		wait_done(1'b1);
		tick(2);
		`CHK("int_n", 1'b1, int_n)
		clr_done();
		int_enable = 1'b1;
		run(`FSQ_OPC_READ, 16'h1FFE, 64'h0, 32);
		`CHK("wrap", 32'h13572468, rd[31:0])
		`CHK("dout", 1'b0, spi_dout)
	endtask

	// Refused frames must leave the stored words untouched
	task automatic t_refuse();
		run(8'h55, 16'h1FFE, 64'h0, 16);
		wait_done(1'b0);
		regulator_en = 1'b0;
		run(`FSQ_OPC_WRITE, 16'h1FFE, 64'h0, 16);
		wait_done(1'b0);
		regulator_en = 1'b1;
		run(`FSQ_OPC_WRITE, 16'h1FFE, 64'h0, 15);
		wait_done(1'b0);
		run(`FSQ_OPC_READ, 16'h1FFE, 64'h0, 32);
		`CHK("kept", 32'h13572468, rd[31:0])
	endtask

	// Erase block 0 through its top byte; block 31 survives
	task automatic t_erase0();
		int k;
		run(`FSQ_OPC_ERASE, 16'h00FF, 64'h0, 0);
		// Clear held through the last erase cycle: the completion must win
		done_clear = 1'b1;
		for (k = 0; k < 300 && mem_busy === 1'b1; k++)
			tick(1);
		done_clear = 1'b0;
		wait_done(1'b1);
		clr_done();
		run(`FSQ_OPC_READ, 16'h1FFE, 64'h0, 32);
		`CHK("erase0", 32'h1357FFFF, rd[31:0])
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Watchdog: the scenarios need well under 60 us
	initial begin
		#300000;
		err_total++;
		summarize();
	end

	// Reset for 8 cycles, then the scenarios in order
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		regulator_en = 1'b1;
		int_enable = 1'b1;
		done_clear = 1'b0;
		tick(8);
		rst_n = 1'b1;
		tick(4);
		t_blank();
		t_erase();
		t_write();
		t_refuse();
		t_erase0();
		summarize();
	end
endmodule
